// >>> rtl/acs_decim.sv
// Counting decimator for the one-bit modulator stream.
// Assumes mod_bit already synchronised and tick one cycle wide.
`timescale 1ns/100ps
module acs_decim (
  // Clock and reset
  input  wire logic        mclk,
  input  wire logic        rst_b,
  // Control
  input  wire logic        start,
  input  wire logic        tick,
  input  wire logic        mod_bit,
  input  wire logic [2:0]  res_code,
  input  wire logic        single_ended,
  // Result
  output logic             done,
  output logic [11:0]      value
);

  typedef struct packed {
    logic        busy;
    logic [12:0] left;
    logic [12:0] ones;
    logic        done;
    logic [11:0] value;
  } acs_dec_state_t;

  acs_dec_state_t r;
  acs_dec_state_t next_r;
  logic [12:0]    half;
  logic [12:0]    ones_now;
  logic signed [13:0] raw;

  always_comb begin
    next_r = r;
    next_r.done = 1'b0;
    half = acs_pkg::rate_of(res_code) >> 1;
    ones_now = r.ones + {12'h000, mod_bit};
    raw = $signed({1'b0, ones_now}) - $signed({1'b0, half});
    if (start) begin
      next_r.busy = 1'b1;
      next_r.left = acs_pkg::rate_of(res_code);
      next_r.ones = 13'h0000;
    end else if (r.busy && tick) begin
      next_r.ones = ones_now;
      next_r.left = r.left - 13'h0001;
      if (r.left == 13'h0001) begin
        next_r.busy = 1'b0;
        next_r.done = 1'b1;
        // Top code folds to half-1 so full scale reads 2047 at 12 bits
        if (raw >= $signed({1'b0, half})) begin
          next_r.value = 12'(half - 13'h0001);
        end else if (single_ended && raw < 14'sh0000) begin
          next_r.value = 12'h000;
        end else begin
          next_r.value = raw[11:0];
        end
      end
    end
  end

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      r <= '0;
    end else begin
      r <= next_r;
    end
  end

  assign done = r.done;
  assign value = r.value;

endmodule // acs_decim

// >>> rtl/acs_pkg.sv
// Constants, types and helpers shared by the conversion sequencer.
// Assumes one system clock and a single-cycle register port master.
package acs_pkg;

  // ----------------------------------------
  // Converter clock and timing
  // ----------------------------------------
  localparam int unsigned SYS_DIV = 8;
  localparam logic [2:0] DIV_LAST = 3'(SYS_DIV - 1);
  localparam logic [4:0] SETTLE_CYC = 5'h10;

  // ----------------------------------------
  // Resolution codes: bits = code + 7
  // ----------------------------------------
  localparam logic [2:0] RES_CODE_MAX = 3'h5;
  localparam logic [2:0] RES_CODE_RST = 3'h5;
  localparam logic [12:0] RATE_BASE = 13'h0080;

  // ----------------------------------------
  // Multiplexer channels
  // ----------------------------------------
  localparam logic [1:0] CH_IN0 = 2'h0;
  localparam logic [1:0] CH_IN1 = 2'h1;
  localparam logic [1:0] CH_TEMP = 2'h2;
  localparam logic [1:0] CH_SUPPLY = 2'h3;
  localparam int unsigned N_CHAN = 4;

  // ----------------------------------------
  // Register map and fields
  // ----------------------------------------
  localparam logic [7:0] A_CTRL = 8'h00;
  localparam logic [7:0] A_STAT = 8'h04;
  localparam logic [7:0] A_RES0 = 8'h08;
  localparam int unsigned CTRL_REQ_BIT = 0;
  localparam int unsigned CTRL_RES_LSB = 1;
  localparam int unsigned CTRL_DIFF_BIT = 4;
  localparam int unsigned STAT_BUSY_BIT = 0;
  localparam int unsigned STAT_CH_LSB = 1;
  localparam int unsigned STAT_DONE_BIT = 3;

  // ----------------------------------------
  // Types
  // ----------------------------------------
  typedef enum logic [1:0] {
    ST_IDLE   = 2'b00,
    ST_SETTLE = 2'b01,
    ST_DECIM  = 2'b11,
    ST_STORE  = 2'b10
  } acs_state_t;

  typedef struct packed {
    logic [7:0]  addr;
    logic [31:0] wdata;
    logic        wr;
    logic        rd;
  } acs_bus_req_t;

  typedef struct packed {
    logic [1:0]  chan;
    logic [11:0] data;
  } acs_result_t;

  // Decimation rate in converter periods
  function automatic logic [12:0] rate_of(input logic [2:0] code);
    rate_of = RATE_BASE << code;
  endfunction

endpackage

// >>> rtl/acs_seq.sv
// Conversion sequencer: register port, converter clock, channel
// walk, multiplexer settling and result store.
// Assumes the analog front end delivers a one-bit modulator stream
// on mod_bit, asynchronous to mclk.
//
// Implementation choices: the register addresses and strobed register access.
`timescale 1ns/100ps
module acs_seq (
  // Clock and reset
  input  wire logic                 mclk,
  input  wire logic                 rst_b,
  // Register port
  input  wire acs_pkg::acs_bus_req_t bus,
  output logic [31:0]               rdata,
  // Analog front end
  input  wire logic                 mod_bit,
  output logic [1:0]                mux_sel,
  output logic                      mux_diff,
  output logic                      ref_internal,
  output logic                      conv_active,
  // Result stream
  output logic                      res_valid,
  output acs_pkg::acs_result_t      res,
  output logic                      seq_done,
  output logic                      busy
);

  // ----------------------------------------
  // State
  // ----------------------------------------
  typedef struct packed {
    logic                sync1;
    logic                sync2;
    logic [2:0]          div;
    logic                tick;
    acs_pkg::acs_state_t state;
    logic [1:0]          chan;
    logic [1:0]          prev_chan;
    logic                prev_valid;
    logic [4:0]          settle;
    logic [2:0]          res_code;
    logic                diff;
    logic                busy;
    logic                seq_seen;
    logic                start;
    logic [3:0][11:0]    result;
    logic [31:0]         rdata;
    logic                res_valid;
    acs_pkg::acs_result_t res_out;
    logic                seq_done;
  } acs_top_state_t;

  acs_top_state_t r;
  acs_top_state_t next_r;
  logic           dec_done;
  logic [11:0]    dec_value;
  logic           single_ended;

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  // A fresh sequence always settles, since the mux may have moved
  function automatic logic needs_settle(
    input logic [1:0] ch,
    input logic [1:0] prev,
    input logic       pv
  );
    needs_settle = !pv || (ch != prev);
  endfunction

  // Differential mode folds both inputs into channel zero
  function automatic logic [1:0] next_chan(
    input logic [1:0] ch,
    input logic       dm
  );
    if (dm && ch == acs_pkg::CH_IN0) begin
      next_chan = acs_pkg::CH_TEMP;
    end else begin
      next_chan = ch + 2'h1;
    end
  endfunction

  function automatic logic [2:0] clamp_code(input logic [2:0] c);
    if (c > acs_pkg::RES_CODE_MAX) begin
      clamp_code = acs_pkg::RES_CODE_MAX;
    end else begin
      clamp_code = c;
    end
  endfunction

  assign single_ended = !(r.diff && r.chan == acs_pkg::CH_IN0);

  // ----------------------------------------
  // Decimator
  // ----------------------------------------
  acs_decim u_decim (
    .mclk         (mclk),
    .rst_b        (rst_b),
    .start        (r.start),
    .tick         (r.tick),
    .mod_bit      (r.sync2),
    .res_code     (r.res_code),
    .single_ended (single_ended),
    .done         (dec_done),
    .value        (dec_value)
  );

  // ----------------------------------------
  // Next state
  // ----------------------------------------
  always_comb begin
    next_r = r;
    next_r.sync1 = mod_bit;
    next_r.sync2 = r.sync1;
    next_r.start = 1'b0;
    next_r.res_valid = 1'b0;
    next_r.seq_done = 1'b0;
    next_r.rdata = 32'h0000_0000;

    // Converter clock as a one-cycle tick every eighth edge
    next_r.tick = 1'b0;
    next_r.div = r.div + 3'h1;
    if (r.div == acs_pkg::DIV_LAST) begin
      next_r.div = 3'h0;
      next_r.tick = 1'b1;
    end

    // Configuration and request; ignored while a sequence runs
    if (bus.wr && bus.addr == acs_pkg::A_CTRL && !r.busy) begin
      next_r.res_code = clamp_code(
        bus.wdata[acs_pkg::CTRL_RES_LSB +: 3]);
      next_r.diff = bus.wdata[acs_pkg::CTRL_DIFF_BIT];
      if (bus.wdata[acs_pkg::CTRL_REQ_BIT]) begin
        next_r.busy = 1'b1;
        next_r.seq_seen = 1'b0;
        next_r.chan = acs_pkg::CH_IN0;
        next_r.prev_valid = 1'b0;
        next_r.state = acs_pkg::ST_SETTLE;
        next_r.settle = acs_pkg::SETTLE_CYC;
      end
    end

    // Sequence walk
    case (r.state)
      acs_pkg::ST_IDLE: begin
        // Request above arms the walk; copying settle back here would lose it
      end
      acs_pkg::ST_SETTLE: begin
        if (r.tick) begin
          if (r.settle == 5'h01) begin
            next_r.state = acs_pkg::ST_DECIM;
            next_r.start = 1'b1;
          end else begin
            next_r.settle = r.settle - 5'h01;
          end
        end
      end
      acs_pkg::ST_DECIM: begin
        if (dec_done) begin
          next_r.result[r.chan] = dec_value;
          next_r.res_out.chan = r.chan;
          next_r.res_out.data = dec_value;
          next_r.res_valid = 1'b1;
          next_r.prev_chan = r.chan;
          next_r.prev_valid = 1'b1;
          next_r.state = acs_pkg::ST_STORE;
        end
      end
      acs_pkg::ST_STORE: begin
        if (r.chan == acs_pkg::CH_SUPPLY) begin
          next_r.state = acs_pkg::ST_IDLE;
          next_r.busy = 1'b0;
          next_r.seq_done = 1'b1;
          next_r.seq_seen = 1'b1;
        end else begin
          next_r.chan = next_chan(r.chan, r.diff);
          if (needs_settle(next_chan(r.chan, r.diff),
                           r.prev_chan, r.prev_valid)) begin
            next_r.state = acs_pkg::ST_SETTLE;
            next_r.settle = acs_pkg::SETTLE_CYC;
          end else begin
            next_r.state = acs_pkg::ST_DECIM;
            next_r.start = 1'b1;
          end
        end
      end
      default: begin
        next_r.state = acs_pkg::ST_IDLE;
        next_r.busy = 1'b0;
      end
    endcase

    // Register reads; unmapped addresses return zero
    if (bus.rd) begin
      if (bus.addr == acs_pkg::A_CTRL) begin
        next_r.rdata[acs_pkg::CTRL_RES_LSB +: 3] = r.res_code;
        next_r.rdata[acs_pkg::CTRL_DIFF_BIT] = r.diff;
      end else if (bus.addr == acs_pkg::A_STAT) begin
        next_r.rdata[acs_pkg::STAT_BUSY_BIT] = r.busy;
        next_r.rdata[acs_pkg::STAT_CH_LSB +: 2] = r.chan;
        next_r.rdata[acs_pkg::STAT_DONE_BIT] = r.seq_seen;
      end
      for (int i = 0; i < acs_pkg::N_CHAN; i++) begin
        if (bus.addr == acs_pkg::A_RES0 + 8'(4 * i)) begin
          // Sign-extend so software reads a signed 32-bit word
          next_r.rdata = {{20{r.result[i][11]}}, r.result[i]};
        end
      end
    end
  end

  // ----------------------------------------
  // Registers
  // ----------------------------------------
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      r <= '0;
      r.state <= acs_pkg::ST_IDLE;
      r.res_code <= acs_pkg::RES_CODE_RST;
    end else begin
      r <= next_r;
    end
  end

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  assign rdata = r.rdata;
  assign mux_sel = r.chan;
  assign mux_diff = r.diff && r.chan == acs_pkg::CH_IN0;
  assign ref_internal = single_ended;
  assign conv_active = r.state == acs_pkg::ST_DECIM;
  assign res_valid = r.res_valid;
  assign res = r.res_out;
  assign seq_done = r.seq_done;
  assign busy = r.busy;

endmodule // acs_seq

// >>> verification/acs_mod_src.sv
// Behavioural modulator stream standing for the analog inputs.
// Assumes a full-scale input, positive or negative, held per sequence.
`timescale 1ns/100ps
module acs_mod_src (
  // Control
  input  wire logic ones,
  // Stream
  output logic      mod_bit
);
  // Offset from the clock on purpose: the real stream is asynchronous
  assign #3 mod_bit = ones;
endmodule // acs_mod_src

// >>> verification/acs_seq_properties.sv
// Port-timing checker for the conversion sequencer.
// Assumes it is bound to acs_seq and sees only that module's ports.
`timescale 1ns/100ps
module acs_seq_chk (
  // Clock and reset
  input wire logic                  mclk,
  input wire logic                  rst_b,
  // Watched ports
  input wire acs_pkg::acs_bus_req_t bus,
  input wire logic [1:0]            mux_sel,
  input wire logic                  mux_diff,
  input wire logic                  ref_internal,
  input wire logic                  conv_active,
  input wire logic                  res_valid,
  input wire acs_pkg::acs_result_t  res,
  input wire logic                  seq_done,
  input wire logic                  busy
);
  // ----------------------------------------
  // Shadow of the configuration and counters
  // ----------------------------------------
  logic [2:0]  code;
  logic        diff;
  logic [15:0] act_len;
  logic [7:0]  gap;
  logic [1:0]  exp_ch;
  logic        cfg_wr;
  assign cfg_wr = bus.wr && bus.addr == acs_pkg::A_CTRL && !busy;
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      code    <= acs_pkg::RES_CODE_RST;
      diff    <= 1'b0;
      act_len <= 16'h0000;
      gap     <= 8'h00;
      exp_ch  <= 2'h0;
    end else begin
      if (cfg_wr) begin
        code <= (bus.wdata[3:1] > 3'h5) ? 3'h5 : bus.wdata[3:1];
        diff <= bus.wdata[4];
      end
      act_len <= conv_active ? act_len + 16'h0001 : 16'h0000;
      gap     <= (busy && !conv_active && !res_valid) ? gap + 8'h01 : 8'h00;
      if (!busy)
        exp_ch <= 2'h0;
      else if (res_valid)
        exp_ch <= (diff && res.chan == 2'h0) ? 2'h2 : res.chan + 2'h1;
    end
  end
  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_b);
  property p_decim_len;
    // Window holds one cycle beside the ticks: the result-take cycle
    $fell(conv_active) |-> act_len == (16'h0400 << code) + 16'h0001;
  endproperty
  a_decim_len: assert property (p_decim_len) else $error("decimation length wrong");
  property p_settle;
    $rose(conv_active) |-> gap >= 8'h78 && gap <= 8'h88;
  endproperty
  a_settle: assert property (p_settle) else $error("settling time wrong");
  property p_start;
    cfg_wr && bus.wdata[0] |=> busy;
  endproperty
  a_start: assert property (p_start) else $error("request did not start");
  property p_order;
    res_valid |-> res.chan == exp_ch;
  endproperty
  a_order: assert property (p_order) else $error("channel order wrong");
  property p_mux_chan;
    conv_active |-> mux_sel == exp_ch;
  endproperty
  a_mux_chan: assert property (p_mux_chan) else $error("mux channel wrong");
  property p_diff_mux;
    conv_active |-> mux_diff == (diff && mux_sel == acs_pkg::CH_IN0);
  endproperty
  a_diff_mux: assert property (p_diff_mux) else $error("differential select wrong");
  property p_ref;
    conv_active |-> ref_internal == !(diff && mux_sel == acs_pkg::CH_IN0);
  endproperty
  a_ref: assert property (p_ref) else $error("reference select wrong");
  property p_se_pos;
    res_valid && !(diff && res.chan == acs_pkg::CH_IN0) |-> !res.data[11];
  endproperty
  a_se_pos: assert property (p_se_pos) else $error("single-ended result negative");
  property p_sext;
    res_valid |-> (res.data >> (code + 4'h6)) == 12'h000
      || (res.data >> (code + 4'h6)) == (12'hFFF >> (code + 4'h6));
  endproperty
  a_sext: assert property (p_sext) else $error("result not sign-extended");
  property p_store_gap;
    res_valid |=> !conv_active [*8];
  endproperty
  a_store_gap: assert property (p_store_gap) else $error("next channel too early");
  property p_done;
    seq_done |-> !busy && $past(res_valid) && res.chan == acs_pkg::CH_SUPPLY;
  endproperty
  a_done: assert property (p_done) else $error("sequence end wrong");
endmodule // acs_seq_chk

bind acs_seq acs_seq_chk u_chk (.mclk(mclk), .rst_b(rst_b), .bus(bus), .mux_sel(mux_sel),
  .mux_diff(mux_diff), .ref_internal(ref_internal), .conv_active(conv_active),
  .res_valid(res_valid), .res(res), .seq_done(seq_done), .busy(busy));

// >>> verification/tb_acs_seq.sv
// Testbench of the conversion sequencer.
// Assumes the modulator source model and the bound checker.
`timescale 1ns/100ps
module tb_acs_seq;
  logic                  mclk = 1'b0;
  logic                  rst_b = 1'b0;
  logic                  ones = 1'b1;
  logic                  mod_bit;
  acs_pkg::acs_bus_req_t bus = '0;
  logic [31:0]           rdata;
  logic [1:0]            mux_sel;
  logic                  mux_diff;
  logic                  ref_internal;
  logic                  conv_active;
  logic                  res_valid;
  logic                  seq_done;
  logic                  busy;
  acs_pkg::acs_result_t  res;
  acs_pkg::acs_result_t  got[$];
  int                    error_cnt = 0;
  int                    num_checks = 0;
  int                    cyc = 0;

  always #5 mclk = ~mclk;
  acs_mod_src src (.ones(ones), .mod_bit(mod_bit));
  acs_seq dut (.mclk(mclk), .rst_b(rst_b), .bus(bus), .rdata(rdata), .mod_bit(mod_bit),
    .mux_sel(mux_sel), .mux_diff(mux_diff), .ref_internal(ref_internal),
    .conv_active(conv_active), .res_valid(res_valid), .res(res), .seq_done(seq_done),
    .busy(busy));
  always @(negedge mclk) if (res_valid) got.push_back(res);

  // ----------------------------------------
  // Tasks
  // ----------------------------------------
  task automatic summarize();
    if (error_cnt == 0 && num_checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  task automatic cmp32(input logic [31:0] g, input logic [31:0] e);
    num_checks++;
    if (g !== e) begin
      error_cnt++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge mclk);
    bus <= '{a, d, 1'b1, 1'b0};
    @(posedge mclk);
    bus.wr <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
    @(posedge mclk);
    bus <= '{a, 32'h00000000, 1'b0, 1'b1};
    @(posedge mclk);
    bus.rd <= 1'b0;
    @(negedge mclk);
    cmp32(rdata & m, e);
  endtask
  // One whole sequence; a refused write is thrown in while busy
  task automatic run(input logic [2:0] c, input logic d, input logic o);
    logic [11:0] v;
    logic [1:0]  ch;
    got.delete();
    ones = o;
    wr(acs_pkg::A_CTRL, {27'h0, d, c, 1'b1});
    rd(acs_pkg::A_STAT, 32'hFFFFFFFF, 32'h00000001);
    wr(acs_pkg::A_CTRL, 32'h0000000B);
    while (!seq_done) @(negedge mclk);
    @(negedge mclk);
    cmp32(32'(got.size()), d ? 32'h3 : 32'h4);
    foreach (got[i]) begin
      ch = (d && i > 0) ? 2'(i + 1) : 2'(i);
      v = o ? 12'((64 << c) - 1) : (d && ch == 2'h0) ? 12'(-(64 << c)) : 12'h000;
      cmp32({18'h0, got[i]}, {18'h0, ch, v});
      rd(8'h08 + {4'h0, ch, 2'b00}, 32'hFFFFFFFF, {{20{v[11]}}, v});
    end
    rd(acs_pkg::A_STAT, 32'hFFFFFFFF, 32'h0000000E);
    rd(acs_pkg::A_CTRL, 32'hFFFFFFFF, {27'h0, d, c, 1'b0});
  endtask

  // ----------------------------------------
  // Watchdog and main sequence
  // ----------------------------------------
  always @(posedge mclk) begin
    cyc <= cyc + 1;
    if (cyc == 40000) begin
      error_cnt++;
      summarize();
    end
  end
  initial begin
    repeat (8) @(posedge mclk);
    rst_b <= 1'b1;
    rd(acs_pkg::A_CTRL, 32'hFFFFFFFF, 32'h0000000A);
    rd(acs_pkg::A_STAT, 32'hFFFFFFFF, 32'h00000000);
    rd(8'h40, 32'hFFFFFFFF, 32'h00000000);
    wr(acs_pkg::A_CTRL, 32'h0000000E);
    rd(acs_pkg::A_CTRL, 32'hFFFFFFFF, 32'h0000000A);
    run(3'h0, 1'b0, 1'b1);
    run(3'h1, 1'b0, 1'b0);
    run(3'h0, 1'b1, 1'b0);
    run(3'h0, 1'b1, 1'b1);
    summarize();
  end
endmodule // tb_acs_seq
